// ===== common/mmbc_pkg.sv
`default_nettype none
package mmbc_pkg;
    // bus machine states
    typedef enum logic [2:0] {
        MMBC_ST_IDLE = 3'b000,
        MMBC_ST_T1 = 3'b001,
        MMBC_ST_T2 = 3'b010,
        MMBC_ST_T3 = 3'b011,
        MMBC_ST_TW = 3'b100,
        MMBC_ST_T4 = 3'b101,
        MMBC_ST_HOLD = 3'b110
    } mmbc_state_t;

    // bus cycle kinds requested by the core
    typedef enum logic [2:0] {
        MMBC_CYC_MEM_RD = 3'b000,
        MMBC_CYC_MEM_WR = 3'b001,
        MMBC_CYC_IO_RD = 3'b010,
        MMBC_CYC_IO_WR = 3'b011,
        MMBC_CYC_IRQ_ACK_STROBE_N = 3'b100
    } mmbc_kind_t;

    // queue operations reported by the core
    typedef enum logic [1:0] {
        MMBC_QOP_NONE = 2'h0,
        MMBC_QOP_FIRST = 2'h1,
        MMBC_QOP_EMPTY = 2'h2,
        MMBC_QOP_NEXT = 2'h3
    } mmbc_qop_t;

    // queue status pin codes
    localparam logic [1:0] MMBC_QS_NONE = 2'h0;
    localparam logic [1:0] MMBC_QS_FIRST = 2'h1;
    localparam logic [1:0] MMBC_QS_EMPTY = 2'h2;
    localparam logic [1:0] MMBC_QS_NEXT = 2'h3;

    // level a floated pin is held to by the bus keeper
    localparam logic MMBC_KEEP_MEM_IO = 1'h0;
    localparam logic MMBC_KEEP_STROBE = 1'h1;

    // reset values
    localparam logic [1:0] MMBC_QS_RESET = 2'h0;
    localparam logic MMBC_STROBE_IDLE = 1'h1;

    function automatic logic mmbc_is_write(input mmbc_kind_t k);
        return (k == MMBC_CYC_MEM_WR) || (k == MMBC_CYC_IO_WR);
    endfunction

    function automatic logic mmbc_is_mem(input mmbc_kind_t k);
        return (k == MMBC_CYC_MEM_RD) || (k == MMBC_CYC_MEM_WR);
    endfunction
endpackage
`default_nettype wire

// ===== common/mmbc_q_if.sv
`default_nettype none
interface mmbc_q_if;
    import mmbc_pkg::*;
    mmbc_qop_t op;
    logic [1:0] status;
    modport core (output op, input status);
    modport enc (input op, output status);
endinterface
`default_nettype wire

// ===== core/mmbc_qstat.sv
`default_nettype none
module mmbc_qstat
    import mmbc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // queue operation in, status out
    mmbc_q_if.enc q
);
    logic [1:0] status_reg;
    wire logic [1:0] status_next;

    function automatic logic [1:0] mmbc_qs_code(input mmbc_qop_t op);
        logic [1:0] c;
        c = MMBC_QS_NONE;
        case (op)
            MMBC_QOP_NONE: c = MMBC_QS_NONE;
            MMBC_QOP_FIRST: c = MMBC_QS_FIRST;
            MMBC_QOP_EMPTY: c = MMBC_QS_EMPTY;
            MMBC_QOP_NEXT: c = MMBC_QS_NEXT;
            default: c = MMBC_QS_NONE;
        endcase
        return c;
    endfunction

    assign status_next = mmbc_qs_code(q.op);

    // shown in the cycle after the operation; the pins are always driven
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            status_reg <= MMBC_QS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign q.status = status_reg;
endmodule // mmbc_qstat
`default_nettype wire

// ===== core/mmbc_top.sv
`default_nettype none
module mmbc_top
    import mmbc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // mode strap
    input wire logic min_max_select,
    // cycle requests from the core
    input wire logic cyc_req,
    input wire mmbc_kind_t cyc_kind,
    output logic cyc_ack,
    output logic cyc_done,
    // queue operations from the core
    input wire mmbc_qop_t queue_op,
    output logic [1:0] queue_status,
    // ready and hold from the system
    input wire logic ready,
    input wire logic hold_req,
    output logic bus_grant,
    // control pins, value and enable (irq_ack_strobe_n and ale have no enable)
    output logic mem_io_sel,
    output logic mem_io_sel_oe,
    output logic wr_n,
    output logic wr_n_oe,
    output logic irq_ack_strobe_n,
    output logic ale,
    output logic xcvr_direction,
    output logic xcvr_direction_oe,
    output logic xcvr_output_enable_n,
    output logic xcvr_output_enable_n_oe,
    // local address/data bus drive enable
    output logic ad_drive,
    // bus machine state, for observation
    output mmbc_state_t bus_state
);
    mmbc_state_t state_reg;
    mmbc_state_t state_next;
    mmbc_kind_t kind_reg;
    logic irq_ack_strobe_n_first_reg;
    logic released_reg;
    logic mem_io_reg;
    logic dir_reg;
    logic wr_n_reg;
    logic irq_ack_strobe_n_n_reg;
    logic den_start_reg;
    logic ad_drive_reg;
    logic done_reg;
    // falling-edge flops for mid-state events
    logic ale_reg;
    logic den_mid_reg;
    logic grant_reg;

    mmbc_q_if q_bus ();

    wire logic min_mode;
    wire logic at_boundary;
    wire logic take_hold;
    wire logic accept;
    wire logic second_irq_ack_strobe_n;
    wire logic in_data_phase_next;
    wire logic cur_write;
    wire logic next_write;
    wire logic next_irq_ack_strobe_n;
    wire mmbc_kind_t next_kind;
    wire logic floated;
    wire logic grant_next;

    assign min_mode = min_max_select;
    assign at_boundary = (state_reg == MMBC_ST_IDLE) || (state_reg == MMBC_ST_T4);
    // the pair of acknowledge cycles is never split by a hold
    assign second_irq_ack_strobe_n = (state_reg == MMBC_ST_T4) && irq_ack_strobe_n_first_reg;
    assign take_hold = min_mode && hold_req && at_boundary && !second_irq_ack_strobe_n;
    assign accept = min_mode && cyc_req && at_boundary && !second_irq_ack_strobe_n && !hold_req;
    assign cyc_ack = accept;
    assign cyc_done = done_reg;

    assign next_kind = accept ? cyc_kind : kind_reg;
    assign cur_write = mmbc_is_write(kind_reg);
    assign next_write = mmbc_is_write(next_kind);
    assign next_irq_ack_strobe_n = (next_kind == MMBC_CYC_IRQ_ACK_STROBE_N);
    assign in_data_phase_next = (state_next == MMBC_ST_T2) || (state_next == MMBC_ST_T3) ||
                                (state_next == MMBC_ST_TW);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            MMBC_ST_IDLE, MMBC_ST_T4: begin
                if (second_irq_ack_strobe_n) begin
                    state_next = MMBC_ST_T1;
                end else if (take_hold) begin
                    state_next = MMBC_ST_HOLD;
                end else if (accept) begin
                    state_next = MMBC_ST_T1;
                end else begin
                    state_next = MMBC_ST_IDLE;
                end
            end
            MMBC_ST_T1: state_next = MMBC_ST_T2;
            MMBC_ST_T2: state_next = MMBC_ST_T3;
            MMBC_ST_T3, MMBC_ST_TW: begin
                state_next = ready ? MMBC_ST_T4 : MMBC_ST_TW;
            end
            MMBC_ST_HOLD: begin
                if (!hold_req) begin
                    state_next = MMBC_ST_IDLE;
                end
            end
            default: state_next = MMBC_ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= MMBC_ST_IDLE;
            kind_reg <= MMBC_CYC_MEM_RD;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= next_kind;
            done_reg <= (state_reg == MMBC_ST_T4) && !irq_ack_strobe_n_first_reg;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            irq_ack_strobe_n_first_reg <= 1'b0;
        end else if (accept) begin
            irq_ack_strobe_n_first_reg <= (cyc_kind == MMBC_CYC_IRQ_ACK_STROBE_N);
        end else if (second_irq_ack_strobe_n) begin
            irq_ack_strobe_n_first_reg <= 1'b0;
        end
    end

    // after hold the pins stay floated until the next cycle is taken
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            released_reg <= 1'b0;
        end else begin
            released_reg <= (released_reg || (state_reg == MMBC_ST_HOLD)) && !accept;
        end
    end

    // cycle attributes change only when a cycle is taken, then stay put through T4
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            mem_io_reg <= 1'b0;
            dir_reg <= 1'b0;
        end else if (accept) begin
            mem_io_reg <= mmbc_is_mem(cyc_kind);
            dir_reg <= mmbc_is_write(cyc_kind);
        end
    end

    // strobes for the state that the next edge enters
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            wr_n_reg <= MMBC_STROBE_IDLE;
            irq_ack_strobe_n_n_reg <= MMBC_STROBE_IDLE;
            den_start_reg <= 1'b0;
            ad_drive_reg <= 1'b0;
        end else begin
            wr_n_reg <= !(in_data_phase_next && next_write);
            irq_ack_strobe_n_n_reg <= !(in_data_phase_next && next_irq_ack_strobe_n);
            den_start_reg <= (state_next == MMBC_ST_T2) && next_write;
            // address in T1, write data T2 to T4; idle for acknowledge cycles
            ad_drive_reg <= !next_irq_ack_strobe_n && ((state_next == MMBC_ST_T1) ||
                            (next_write && (in_data_phase_next || state_next == MMBC_ST_T4)));
        end
    end

    assign grant_next = min_mode && hold_req &&
                        ((state_reg == MMBC_ST_IDLE) || (state_reg == MMBC_ST_HOLD) ||
                         ((state_reg == MMBC_ST_T4) && !irq_ack_strobe_n_first_reg));

    // falling edge gives the half-clock placement of these pins
    always_ff @(negedge mclk or posedge reset) begin
        if (reset) begin
            ale_reg <= 1'b0;
            den_mid_reg <= 1'b0;
            grant_reg <= 1'b0;
        end else begin
            ale_reg <= (state_reg == MMBC_ST_T1);
            den_mid_reg <= (state_reg == MMBC_ST_T2) || (state_reg == MMBC_ST_T3) ||
                           (state_reg == MMBC_ST_TW);
            grant_reg <= grant_next;
        end
    end

    assign floated = grant_reg || released_reg;

    assign bus_grant = grant_reg;
    assign bus_state = state_reg;

    assign mem_io_sel = floated ? MMBC_KEEP_MEM_IO : mem_io_reg;
    assign mem_io_sel_oe = min_mode && !floated;
    assign xcvr_direction = floated ? MMBC_KEEP_STROBE : dir_reg;
    assign xcvr_direction_oe = min_mode && !floated;
    assign wr_n = floated ? MMBC_KEEP_STROBE : wr_n_reg;
    assign wr_n_oe = min_mode && !floated;
    // read and acknowledge enable from mid T2; a write adds the first half of T2
    assign xcvr_output_enable_n = floated ? MMBC_KEEP_STROBE :
                                  !(den_mid_reg || (den_start_reg && cur_write));
    assign xcvr_output_enable_n_oe = min_mode && !floated;
    // never floated, only held inactive outside minimum mode
    assign irq_ack_strobe_n = irq_ack_strobe_n_n_reg || !min_mode;
    // cut at the end of T1 so the pulse covers only the low half of T1
    assign ale = ale_reg && min_mode && (state_reg == MMBC_ST_T1);
    assign ad_drive = ad_drive_reg && !floated;

    assign q_bus.op = queue_op;
    assign queue_status = q_bus.status;

    mmbc_qstat u_qstat (
        .mclk(mclk),
        .reset(reset),
        .q(q_bus)
    );
endmodule // mmbc_top
`default_nettype wire

// ===== testbench/mmbc_top_asserts.sv
`default_nettype none
module mmbc_top_asserts
    import mmbc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // watched pins
    input wire logic min_max_select,
    input wire mmbc_qop_t queue_op,
    input wire logic [1:0] queue_status,
    input wire logic ready,
    input wire logic hold_req,
    input wire logic bus_grant,
    input wire logic mem_io_sel,
    input wire logic mem_io_sel_oe,
    input wire logic wr_n,
    input wire logic wr_n_oe,
    input wire logic irq_ack_strobe_n,
    input wire logic ale,
    input wire logic xcvr_direction,
    input wire logic xcvr_output_enable_n,
    input wire logic ad_drive,
    input wire mmbc_state_t bus_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_qs_follow: assert property (1 |=> queue_status == $past(queue_op))
        else $error("queue status does not follow queue op");
    a_wr_window: assert property (!wr_n |-> bus_state inside {MMBC_ST_T2, MMBC_ST_T3, MMBC_ST_TW})
        else $error("write strobe outside T2..TW");
    a_ack_window: assert property (!irq_ack_strobe_n |-> bus_state inside {MMBC_ST_T2, MMBC_ST_T3, MMBC_ST_TW})
        else $error("acknowledge strobe outside T2..TW");
    a_ale_t1: assert property (min_max_select |-> ((bus_state == MMBC_ST_T1) == ale))
        else $error("latch pulse not tied to T1");
    a_grant_float: assert property (bus_grant |-> !mem_io_sel_oe && !mem_io_sel && !wr_n_oe && wr_n && !ad_drive)
        else $error("pins driven while granted");
    a_grant_drop: assert property (bus_state == MMBC_ST_HOLD && !hold_req |=> !bus_grant)
        else $error("grant kept after request dropped");
    a_ready_wait: assert property (bus_state inside {MMBC_ST_T3, MMBC_ST_TW} && !ready |=> bus_state == MMBC_ST_TW)
        else $error("no wait state while not ready");
    a_seq_order: assert property (bus_state == MMBC_ST_T1 |=> bus_state == MMBC_ST_T2 ##1 bus_state == MMBC_ST_T3)
        else $error("bus states out of order");
    a_den_active: assert property (bus_state inside {MMBC_ST_T2, MMBC_ST_T3, MMBC_ST_TW} |-> !xcvr_output_enable_n)
        else $error("transceiver enable idle in transfer");
    a_den_ends: assert property (bus_state inside {MMBC_ST_T1, MMBC_ST_T4} |-> xcvr_output_enable_n)
        else $error("transceiver enable active at T1 or end of T4");
    a_sel_stable: assert property (bus_state inside {MMBC_ST_T2, MMBC_ST_T3, MMBC_ST_TW, MMBC_ST_T4}
        |-> $stable(mem_io_sel) && $stable(xcvr_direction))
        else $error("select or direction moved mid cycle");
    a_max_quiet: assert property (!min_max_select |-> !ale && irq_ack_strobe_n && !mem_io_sel_oe)
        else $error("pins active in other mode");
endmodule // mmbc_top_asserts
`default_nettype wire

// ===== testbench/mmbc_far_model.sv
`default_nettype none
module mmbc_far_model
    import mmbc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // scenario controls
    input wire logic want_bus,
    input wire logic [3:0] wait_cnt,
    // local bus side
    input wire mmbc_state_t bus_state,
    input wire logic bus_grant,
    output logic hold_req,
    output logic ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_reg;
    wire in_wait = (bus_state == MMBC_ST_T3) || (bus_state == MMBC_ST_TW);
    // slow memory: ready low for wait_cnt samples of every cycle
    assign ready = !in_wait || (wait_reg >= wait_cnt);
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            hold_req <= 1'b0;
            wait_reg <= 4'h0;
        end else begin
            // changed only on the clock, kept up until granted
            hold_req <= want_bus || (hold_req && !bus_grant);
            wait_reg <= in_wait ? wait_reg + 4'h1 : 4'h0;
        end
    end
endmodule // mmbc_far_model
`default_nettype wire

// ===== testbench/min_mode_bus_control_bench.sv
`default_nettype none
module min_mode_bus_control_bench
    import mmbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic min_max_select = 1'b1;
    logic cyc_req = 1'b0;
    mmbc_kind_t cyc_kind = MMBC_CYC_MEM_RD;
    mmbc_qop_t queue_op = MMBC_QOP_NONE;
    logic want_bus = 1'b0;
    logic [3:0] wait_cnt = 4'h0;
    logic ready, hold_req, cyc_ack, cyc_done, bus_grant, mem_io_sel, mem_io_sel_oe, wr_n, wr_n_oe;
    logic irq_ack_strobe_n, ale, xcvr_direction, xcvr_direction_oe, xcvr_output_enable_n;
    logic xcvr_output_enable_n_oe, ad_drive;
    logic [1:0] queue_status;
    mmbc_state_t bus_state;
    int err_total = 0;
    int checks_done = 0;

    always #2.5 mclk = ~mclk;

    mmbc_top mmbc_top_i (.mclk, .reset, .min_max_select, .cyc_req, .cyc_kind, .cyc_ack, .cyc_done,
        .queue_op, .queue_status, .ready, .hold_req, .bus_grant, .mem_io_sel, .mem_io_sel_oe, .wr_n,
        .wr_n_oe, .irq_ack_strobe_n, .ale, .xcvr_direction, .xcvr_direction_oe, .xcvr_output_enable_n,
        .xcvr_output_enable_n_oe, .ad_drive, .bus_state);
    mmbc_far_model mmbc_far_model_i (.mclk, .reset, .want_bus, .wait_cnt, .bus_state, .bus_grant,
        .hold_req, .ready);

    task automatic report_and_stop();
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            err_total++;
            $display("ERROR %0t wait ran out", $time);
            report_and_stop();
        end
    endtask

    task automatic queue_test();
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            queue_op <= mmbc_qop_t'(i[1:0]);
            @(posedge mclk);
            #1;
            chk({2'h0, queue_status}, 4'(i));
        end
    endtask

    task automatic run_cycle(input mmbc_kind_t k, input logic [3:0] w);
        int n;
        int t1s;
        int tws;
        logic wr;
        logic ia;
        n = 0;
        t1s = 0;
        tws = 0;
        wr = (k == MMBC_CYC_MEM_WR) || (k == MMBC_CYC_IO_WR);
        ia = (k == MMBC_CYC_IRQ_ACK_STROBE_N);
        @(posedge mclk);
        cyc_req <= 1'b1;
        cyc_kind <= k;
        wait_cnt <= w;
        do begin
            @(negedge mclk);
            n++;
        end while (cyc_ack !== 1'b1 && n < 20);
        guard(n, 20);
        @(posedge mclk);
        cyc_req <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            #1;
            n++;
            if (bus_state === MMBC_ST_TW) tws++;
            if (bus_state === MMBC_ST_T1) begin
                t1s++;
                chk(ale, 1);
                chk(ad_drive, !ia);
            end
            if (bus_state === MMBC_ST_T2) begin
                chk(mem_io_sel, k inside {MMBC_CYC_MEM_RD, MMBC_CYC_MEM_WR});
                chk(xcvr_direction, wr);
                chk(wr_n, !wr);
                chk(irq_ack_strobe_n, !ia);
                chk(ad_drive, wr);
                chk(xcvr_output_enable_n, 0);
            end
            @(posedge mclk);
            #1;
            if (bus_state === MMBC_ST_T2) begin
                chk(xcvr_output_enable_n, !wr);
                chk(ale, 0);
            end
        end while (cyc_done !== 1'b1 && n < 60);
        guard(n, 60);
        chk(4'(t1s), ia ? 4'h2 : 4'h1);
        chk(4'(tws), ia ? 4'(2 * w) : w);
    endtask

    task automatic hold_test();
        int n;
        n = 0;
        @(posedge mclk);
        want_bus <= 1'b1;
        do begin
            @(negedge mclk);
            #1;
            n++;
        end while (bus_grant !== 1'b1 && n < 20);
        guard(n, 20);
        chk({mem_io_sel_oe, mem_io_sel, wr_n_oe, ad_drive}, 4'h0);
        chk({xcvr_direction_oe, xcvr_output_enable_n_oe}, 4'h0);
        chk({wr_n, xcvr_direction, xcvr_output_enable_n, irq_ack_strobe_n}, 4'hf);
        @(posedge mclk);
        cyc_req <= 1'b1;
        repeat (4) begin
            @(negedge mclk);
            chk(cyc_ack, 0);
        end
        @(posedge mclk);
        cyc_req <= 1'b0;
        want_bus <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk);
            #1;
            n++;
        end while (bus_grant !== 1'b0 && n < 20);
        guard(n, 20);
        repeat (3) @(posedge mclk);
        #1;
        chk(mem_io_sel_oe, 0);
        run_cycle(MMBC_CYC_IO_RD, 4'h0);
        chk(mem_io_sel_oe, 1);
    endtask

    task automatic max_test();
        @(posedge mclk);
        min_max_select <= 1'b0;
        cyc_req <= 1'b1;
        repeat (5) begin
            @(negedge mclk);
            chk({cyc_ack, ale, mem_io_sel_oe, irq_ack_strobe_n}, 4'h1);
        end
        @(posedge mclk);
        min_max_select <= 1'b1;
        cyc_req <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        queue_test();
        for (int i = 0; i < 5; i++) run_cycle(mmbc_kind_t'(i), 4'(i % 3));
        hold_test();
        max_test();
        run_cycle(MMBC_CYC_MEM_WR, 4'h0);
        report_and_stop();
    end
endmodule // min_mode_bus_control_bench

bind mmbc_top mmbc_top_asserts mmbc_top_asserts_i (.mclk, .reset, .min_max_select, .queue_op, .queue_status,
    .ready, .hold_req, .bus_grant, .mem_io_sel, .mem_io_sel_oe, .wr_n, .wr_n_oe, .irq_ack_strobe_n, .ale,
    .xcvr_direction, .xcvr_output_enable_n, .ad_drive, .bus_state);
`default_nettype wire
